/* bench/nco_pll_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nco_pll_defines.svh"

// Self-checking bench for the NCO step and PLL setup registers
module nco_pll_regs_tb_top
	import nco_pll_pkg::*;
;
	logic sys_clk = 1'b0; // 100 MHz system clock
	logic rst_b = 1'b0; // Async reset, active low
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Wishbone request
	logic [7:0] adr = 8'h00; // Byte address
	logic [3:0] sel = 4'h0; // Byte lanes
	logic [31:0] dat = 32'h0; // Write data
	logic lvds_sync = 1'b0; // Alignment strobe pin
	logic [2:0] lvl = 3'h0; // Loop filter level pins
	logic [31:0] dat_o, step1, step2; // Read data and active steps
	logic [15:0] ph1, ph2; // Lookup phases
	logic ack, ld1, ld2, hold, syncp, pllsel, pok, prok, mok; // Flags
	charge_pump_t pump; // Decoded pump mode
	logic [3:0] pre; // Prescale ratio
	logic [7:0] m; // M ratio
	logic [4:0] n; // N ratio
	logic [1:0] bias; // Bias trim
	logic [5:0] coarse; // Coarse tuning
	logic [7:0] mt [4] = '{8'h03, 8'h04, 8'h84, 8'h83}; // M corner codes
	int fails = 0, comparisons = 0, n_ld1 = 0, n_ld2 = 0, n_sp = 0; // Counters

	// Free-running clock
	always #5 sys_clk = ~sys_clk;

	nco_pll_regs dut (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .lvds_sync(lvds_sync), .loop_filter_level(lvl),
		.nco_step_first_pair(step1), .nco_step_second_pair(step2),
		.first_pair_lut_phase(ph1), .second_pair_lut_phase(ph2),
		.mixer_load_first(ld1), .mixer_load_second(ld2), .loop_filter_hold(hold),
		.ndiv_sync_pulse(syncp), .pll_clock_select(pllsel), .charge_pump_select(pump),
		.pump_code_ok(pok), .prescale_ratio(pre), .prescale_ok(prok), .m_ratio(m),
		.m_ratio_ok(mok), .n_ratio(n), .bias_trim(bias), .coarse_tuning(coarse));

	// Pulse counters; single-cycle pulses are easy to miss by polling
	always @(posedge sys_clk) begin
		if (ld1 === 1'b1) n_ld1++;
		if (ld2 === 1'b1) n_ld2++;
		if (syncp === 1'b1) n_sp++;
	end

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One classic cycle; waits for ack with a bound, then releases
	task wb(input logic w, input logic [5:0] i, input logic [15:0] d, output logic [15:0] q);
		int k;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		sel <= 4'h3;
		dat <= {16'($urandom), d};
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) chk("wb_ack_o", {31'h0, ack}, 32'h1);
		q = dat_o[15:0];
		if (!w) chk("wb_dat_o upper", {16'h0, dat_o[31:16]}, 32'h0);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task wr(input logic [5:0] i, input logic [15:0] d);
		logic [15:0] q;
		wb(1'b1, i, d, q);
	endtask

	task rdc(input string nm, input logic [5:0] i, input logic [15:0] exp);
		logic [15:0] q;
		wb(1'b0, i, 16'h0, q);
		chk(nm, {16'h0, q}, {16'h0, exp});
	endtask

	// Control readback: fixed reserved bits, written fields, live level
	function logic [15:0] ctl_exp(logic [15:0] w, logic [2:0] l);
		return (`RST_PLL_CTL & ~`MASK_PLL_CTL) | (w & `MASK_PLL_CTL) | {13'h0, l};
	endfunction

	// Prescaler code to ratio; code 001 has no ratio
	function logic [3:0] pre_exp(logic [2:0] c);
		return (c == 3'h0) ? 4'h8 : (c == 3'h1) ? 4'h0 : {1'b0, c};
	endfunction

	task end_sim;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		end_sim;
	end

	initial begin
		logic [15:0] w, h;
		logic [31:0] s, e2;
		int c;
		c = $urandom(38);
		e2 = 32'h0;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("n_ratio", {27'h0, n}, 32'h5);
		chk("m_ratio", {24'h0, m}, 32'h4);
		chk("m_ratio_ok", {31'h0, mok}, 32'h1);
		chk("prescale_ok", {31'h0, prok}, 32'h0);
		rdc("ab_hi reset", 6'h15, 16'h0000);
		rdc("cd_lo reset", 6'h16, 16'h0000);
		rdc("cd_hi reset", 6'h17, 16'h0000);
		rdc("ctl reset", 6'h18, `RST_PLL_CTL);
		rdc("div reset", 6'h19, 16'h0440);
		$display("test reset done");
		// Second pair: halves stay inactive until the offset is written
		for (c = 0; c < 4; c++) begin
			s = $urandom;
			wr(6'h16, s[15:0]);
			wr(6'h17, s[31:16]);
			rdc("cd_lo", 6'h16, s[15:0]);
			rdc("cd_hi", 6'h17, s[31:16]);
			chk("second step held", step2, e2);
			wr(6'h13, 16'($urandom));
			repeat (3) @(posedge sys_clk);
			chk("load pulses", n_ld2, c + 1);
			chk("second step", step2, s);
			e2 = s;
		end
		// First pair, whole-turn steps so the lookup phase moves exactly
		for (c = 0; c < 4; c++) begin
			s = {16'($urandom), 16'h0};
			s[31] = (c < 2); // Negative steps first
			wr(6'h14, 16'h0);
			wr(6'h15, s[31:16]);
			rdc("ab_lo", 6'h14, 16'h0);
			rdc("ab_hi", 6'h15, s[31:16]);
			wr(6'h12, 16'($urandom));
			repeat (4) @(posedge sys_clk);
			chk("first load pulses", n_ld1, c + 1);
			chk("first step", step1, s);
			h = ph1;
			@(posedge sys_clk);
			chk("phase advance", {16'h0, 16'(ph1 - h)}, {16'h0, s[31:16]});
		end
		$display("test steps done");
		// Control: every pump and prescaler code, random other bits
		for (c = 0; c < 8; c++) begin
			w = $urandom;
			w[7:6] = c[1:0];
			w[5:3] = c[2:0];
			lvl <= 3'($urandom);
			wr(6'h18, w);
			repeat (3) @(posedge sys_clk);
			rdc("ctl", 6'h18, ctl_exp(w, lvl));
			chk("hold", {31'h0, hold}, {31'h0, w[12]});
			chk("clock select", {31'h0, pllsel}, {31'h0, w[10]});
			chk("pump", {30'h0, pump}, {30'h0, w[7:6]});
			chk("pump ok", {31'h0, pok}, {31'h0, w[7:6] != 2'b10});
			chk("prescale", {28'h0, pre}, {28'h0, pre_exp(w[5:3])});
			chk("prescale ok", {31'h0, prok}, {31'h0, w[5:3] != 3'h1});
		end
		$display("test control done");
		// Divider: every N code, M corners then random
		for (c = 0; c < 16; c++) begin
			w = $urandom;
			w[7:4] = c[3:0];
			if (c < 4) w[15:8] = mt[c];
			wr(6'h19, w);
			repeat (3) @(posedge sys_clk);
			rdc("div", 6'h19, w & `MASK_PLL_DIV);
			chk("m", {24'h0, m}, {24'h0, w[15] ? {w[14:8], 1'b0} : {1'b0, w[14:8]}});
			chk("m ok", {31'h0, mok}, {31'h0, w[14:8] >= 7'h04});
			chk("n", {27'h0, n}, c + 1);
			chk("bias", {30'h0, bias}, {30'h0, w[3:2]});
		end
		// Normal operation wants bias trim 01 with reset M and N
		wr(6'h19, 16'h0444);
		repeat (3) @(posedge sys_clk);
		chk("bias normal", {30'h0, bias}, 32'h1);
		$display("test divider done");
		w = $urandom;
		wr(6'h1a, w);
		rdc("coarse reg", 6'h1a, w & `MASK_VCO_TUNE);
		chk("coarse", {26'h0, coarse}, {26'h0, w[15:10]});
		wr(6'h3f, w);
		rdc("unmapped", 6'h3f, 16'h0);
		// Software nudges coarse tuning while the level is outside 010..101
		lvl <= 3'h1;
		repeat (3) @(posedge sys_clk);
		wb(1'b0, 6'h18, 16'h0, h);
		if (h[2:0] < 3'h2 || h[2:0] > 3'h5) begin
			wr(6'h1a, 16'h0400);
		end
		chk("coarse tuned", {26'h0, coarse}, 32'h1);
		$display("test coarse and unmapped done");
		// Divider alignment strobe, enabled then disabled
		wr(6'h18, 16'h0800);
		c = n_sp;
		lvds_sync <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk("sync on", n_sp - c, 1);
		lvds_sync <= 1'b0;
		wr(6'h18, 16'h0000);
		repeat (3) @(posedge sys_clk);
		c = n_sp;
		lvds_sync <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk("sync off", n_sp - c, 0);
		lvds_sync <= 1'b0;
		$display("test sync done");
		end_sim;
	end
endmodule
`default_nettype wire

/* design/nco_accum.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nco_pll_defines.svh"

// Phase accumulator for one channel pair, one sample per clock
module nco_accum
	import nco_pll_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [31:0] step,
	input wire logic [15:0] offset,
	output logic [15:0] lut_phase
);

	acc_state_t s_r; // Registered state
	acc_state_t s_nxt; // Next state

	// Signed step wraps modulo 2^32, so a negative word turns backwards
	always_comb begin
		s_nxt = s_r;
		s_nxt.phase = s_r.phase + step;
		s_nxt.lut_phase = s_r.phase[31:16] + offset;
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lut_phase = s_r.lut_phase;

	a_phase_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> s_r.phase == 32'($past(s_r.phase) + $past(step)))
		else $error("phase did not advance by the step");

endmodule
`default_nettype wire

/* design/nco_pll_defines.svh */
`ifndef NCO_PLL_DEFINES_SVH
`define NCO_PLL_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_OFS_AB 6'h12
`define IDX_OFS_CD 6'h13
`define IDX_STEP_AB_LO 6'h14
`define IDX_STEP_AB_HI 6'h15
`define IDX_STEP_CD_LO 6'h16
`define IDX_STEP_CD_HI 6'h17
`define IDX_PLL_CTL 6'h18
`define IDX_PLL_DIV 6'h19
`define IDX_VCO_TUNE 6'h1a

// Reset values
`define RST_ZERO 16'h0000
`define RST_PLL_CTL 16'h2808
`define RST_PLL_DIV 16'h0440

// Writable bit masks; other bits keep their reset value
`define MASK_ALL 16'hffff
`define MASK_PLL_CTL 16'h1cf8
`define MASK_PLL_DIV 16'hfffc
`define MASK_VCO_TUNE 16'hfc00

// Field positions in the PLL control register
`define PLL_RST_BIT 12
`define NDIVSYNC_BIT 11
`define PLL_ENA_BIT 10
`define CP_HI 7
`define CP_LO 6
`define PRE_HI 5
`define PRE_LO 3
`define LF_HI 2
`define LF_LO 0

// Field positions in the divider setup register
`define M_HI 15
`define M_LO 8
`define N_HI 7
`define N_LO 4
`define VCOI_HI 3
`define VCOI_LO 2

// Coarse tuning field position
`define VCO_HI 15
`define VCO_LO 10

// Least legal M code in the low seven bits
`define M_MIN 7'h04

`endif

/* design/nco_pll_pkg.sv */
package nco_pll_pkg;

	// Charge pump modes
	typedef enum logic [1:0] {
		PUMP_NONE = 2'b00,
		PUMP_SINGLE = 2'b01,
		PUMP_UNUSED = 2'b10,
		PUMP_DUAL = 2'b11
	} charge_pump_t;

	// Register block state
	typedef struct packed {
		logic [15:0] ab_lo;
		logic [15:0] ab_hi;
		logic [15:0] cd_lo;
		logic [15:0] cd_hi;
		logic [15:0] ofs_ab;
		logic [15:0] ofs_cd;
		logic [15:0] ctl;
		logic [15:0] div;
		logic [15:0] vco;
		logic [31:0] act_ab;
		logic [31:0] act_cd;
		logic [15:0] act_ofs_ab;
		logic [15:0] act_ofs_cd;
		logic ack;
		logic [31:0] dat;
		logic sync1;
		logic sync2;
		logic sync3;
		logic [2:0] lf1;
		logic [2:0] lf2;
		logic ndiv_pulse;
		logic load_ab;
		logic load_cd;
	} regs_state_t;

	// Accumulator state
	typedef struct packed {
		logic [31:0] phase;
		logic [15:0] lut_phase;
	} acc_state_t;

	// Decoded divider state
	typedef struct packed {
		charge_pump_t pump;
		logic pump_ok;
		logic [3:0] pre;
		logic pre_ok;
		logic [7:0] m;
		logic m_ok;
		logic [4:0] n;
	} ratio_state_t;

endpackage

/* design/nco_pll_regs.sv */
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "nco_pll_defines.svh"

module nco_pll_regs
	import nco_pll_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	// Classic Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins from outside this clock domain
	input wire logic lvds_sync,
	input wire logic [2:0] loop_filter_level,
	// Mixer side
	output logic [31:0] nco_step_first_pair,
	output logic [31:0] nco_step_second_pair,
	output logic [15:0] first_pair_lut_phase,
	output logic [15:0] second_pair_lut_phase,
	output logic mixer_load_first,
	output logic mixer_load_second,
	// PLL side
	output logic loop_filter_hold,
	output logic ndiv_sync_pulse,
	output logic pll_clock_select,
	output charge_pump_t charge_pump_select,
	output logic pump_code_ok,
	output logic [3:0] prescale_ratio,
	output logic prescale_ok,
	output logic [7:0] m_ratio,
	output logic m_ratio_ok,
	output logic [4:0] n_ratio,
	output logic [1:0] bias_trim,
	output logic [5:0] coarse_tuning
);

	regs_state_t s_r; // Registered state
	regs_state_t s_nxt; // Next state
	logic [5:0] idx; // Word index of the access
	logic take; // Request taken this cycle
	logic wr; // Write taken this cycle

	// Only the word index matters; byte offset bits are ignored
	assign idx = wb_adr_i[7:2];
	// One wait state: take on the first cycle, ack on the next
	assign take = wb_cyc_i && wb_stb_i && !s_r.ack;
	assign wr = take && wb_we_i;

	// Byte-lane merge of a 16-bit register, keeping non-writable bits
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0] sel,
		input logic [15:0] mask
	);
		logic [15:0] m;
		m = old;
		if (sel[0]) begin
			m[7:0] = data[7:0];
		end
		if (sel[1]) begin
			m[15:8] = data[15:8];
		end
		merge16 = (old & ~mask) | (m & mask);
	endfunction

	// Read multiplexer; narrow registers sit in the low half
	function automatic logic [15:0] read16(
		input regs_state_t s,
		input logic [5:0] i
	);
		case (i)
			`IDX_OFS_AB: begin
				read16 = s.ofs_ab;
			end
			`IDX_OFS_CD: begin
				read16 = s.ofs_cd;
			end
			`IDX_STEP_AB_LO: begin
				read16 = s.ab_lo;
			end
			`IDX_STEP_AB_HI: begin
				read16 = s.ab_hi;
			end
			`IDX_STEP_CD_LO: begin
				read16 = s.cd_lo;
			end
			`IDX_STEP_CD_HI: begin
				read16 = s.cd_hi;
			end
			`IDX_PLL_CTL: begin
				// Live level replaces the stored low bits
				read16 = {s.ctl[15:3], s.lf2};
			end
			`IDX_PLL_DIV: begin
				read16 = s.div;
			end
			`IDX_VCO_TUNE: begin
				read16 = s.vco & `MASK_VCO_TUNE;
			end
			default: begin
				// Unmapped words read as zero
				read16 = `RST_ZERO;
			end
		endcase
	endfunction

	// Next-state logic for bus, registers, loads and pin sampling
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = take;
		s_nxt.load_ab = 1'b0;
		s_nxt.load_cd = 1'b0;
		// Read data captured with the request, held until the next one
		if (take && !wb_we_i) begin
			s_nxt.dat = {16'h0000, read16(s_r, idx)};
		end
		// Register writes; unmapped writes are dropped but still acked
		if (wr) begin
			case (idx)
				`IDX_OFS_AB: begin
					s_nxt.ofs_ab = merge16(s_r.ofs_ab, wb_dat_i, wb_sel_i, `MASK_ALL);
					s_nxt.load_ab = 1'b1;
				end
				`IDX_OFS_CD: begin
					s_nxt.ofs_cd = merge16(s_r.ofs_cd, wb_dat_i, wb_sel_i, `MASK_ALL);
					s_nxt.load_cd = 1'b1;
				end
				`IDX_STEP_AB_LO: begin
					s_nxt.ab_lo = merge16(s_r.ab_lo, wb_dat_i, wb_sel_i, `MASK_ALL);
				end
				`IDX_STEP_AB_HI: begin
					s_nxt.ab_hi = merge16(s_r.ab_hi, wb_dat_i, wb_sel_i, `MASK_ALL);
				end
				`IDX_STEP_CD_LO: begin
					s_nxt.cd_lo = merge16(s_r.cd_lo, wb_dat_i, wb_sel_i, `MASK_ALL);
				end
				`IDX_STEP_CD_HI: begin
					s_nxt.cd_hi = merge16(s_r.cd_hi, wb_dat_i, wb_sel_i, `MASK_ALL);
				end
				`IDX_PLL_CTL: begin
					// Level bits and reserved bits are not writable
					s_nxt.ctl = merge16(s_r.ctl, wb_dat_i, wb_sel_i, `MASK_PLL_CTL);
				end
				`IDX_PLL_DIV: begin
					s_nxt.div = merge16(s_r.div, wb_dat_i, wb_sel_i, `MASK_PLL_DIV);
				end
				`IDX_VCO_TUNE: begin
					s_nxt.vco = merge16(s_r.vco, wb_dat_i, wb_sel_i, `MASK_VCO_TUNE);
				end
				default: begin
					s_nxt.vco = s_r.vco;
				end
			endcase
		end
		// Offset write moves the shadow step words into the mixer one cycle after the load pulse,
		// so a half-written step never reaches the accumulator
		if (s_r.load_ab) begin
			s_nxt.act_ab = {s_r.ab_hi, s_r.ab_lo};
			s_nxt.act_ofs_ab = s_r.ofs_ab;
		end
		if (s_r.load_cd) begin
			s_nxt.act_cd = {s_r.cd_hi, s_r.cd_lo};
			s_nxt.act_ofs_cd = s_r.ofs_cd;
		end
		// Two-stage synchronisers; the level uses the second stage, the strobe edge compares the second and a third stage
		s_nxt.sync1 = lvds_sync;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.sync3 = s_r.sync2;
		s_nxt.lf1 = loop_filter_level;
		s_nxt.lf2 = s_r.lf1;
		// Rising strobe aligns the dividers only while enabled
		s_nxt.ndiv_pulse = s_r.sync2 && !s_r.sync3 && s_r.ctl[`NDIVSYNC_BIT];
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
			s_r.ctl <= `RST_PLL_CTL;
			s_r.div <= `RST_PLL_DIV;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Per-pair phase accumulators
	nco_accum u_acc_first (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.step(s_r.act_ab),
		.offset(s_r.act_ofs_ab),
		.lut_phase(first_pair_lut_phase)
	);

	nco_accum u_acc_second (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.step(s_r.act_cd),
		.offset(s_r.act_ofs_cd),
		.lut_phase(second_pair_lut_phase)
	);

	// Divider and pump decode
	pll_ratio_decode u_dec (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.ctl(s_r.ctl),
		.div(s_r.div),
		.charge_pump_select(charge_pump_select),
		.pump_code_ok(pump_code_ok),
		.prescale_ratio(prescale_ratio),
		.prescale_ok(prescale_ok),
		.m_ratio(m_ratio),
		.m_ratio_ok(m_ratio_ok),
		.n_ratio(n_ratio)
	);

	// Outputs straight from registers
	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.dat;
	assign nco_step_first_pair = s_r.act_ab;
	assign nco_step_second_pair = s_r.act_cd;
	assign mixer_load_first = s_r.load_ab;
	assign mixer_load_second = s_r.load_cd;
	assign loop_filter_hold = s_r.ctl[`PLL_RST_BIT];
	assign ndiv_sync_pulse = s_r.ndiv_pulse;
	assign pll_clock_select = s_r.ctl[`PLL_ENA_BIT];
	assign bias_trim = s_r.div[`VCOI_HI:`VCOI_LO];
	assign coarse_tuning = s_r.vco[`VCO_HI:`VCO_LO];

	a_ack_follows: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle after request");

	a_cd_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!mixer_load_second |=> $stable(nco_step_second_pair))
		else $error("second pair step changed without load");

	a_cd_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wr && idx == 6'h13) |=> ##1 nco_step_second_pair == {$past(s_r.cd_hi), $past(s_r.cd_lo)})
		else $error("offset write did not load step");

	a_lf_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wr && idx == 6'h18 && wb_sel_i[1]) |=> loop_filter_hold == $past(wb_dat_i[12]))
		else $error("filter hold not following write");

	a_clk_select: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wr && idx == 6'h18 && wb_sel_i[1]) |=> pll_clock_select == $past(wb_dat_i[10]))
		else $error("clock select not following write");

	a_sync_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ndiv_sync_pulse |-> $past(s_r.ctl[11]) && $past(s_r.sync2) && !$past(s_r.sync3))
		else $error("divider sync without enable or edge");

	a_level_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(take && !wb_we_i && idx == 6'h18) |=> wb_dat_o[2:0] == $past(s_r.lf2))
		else $error("level bits not live on read");

	a_step_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(take && !wb_we_i && idx == 6'h17) |=> wb_dat_o == {16'h0000, $past(s_r.cd_hi)})
		else $error("second pair high half misread");

endmodule
`default_nettype wire

/* design/pll_ratio_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nco_pll_defines.svh"

// Turns PLL setup codes into plain ratios, one cycle behind the registers
module pll_ratio_decode
	import nco_pll_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [15:0] ctl,
	input wire logic [15:0] div,
	output charge_pump_t charge_pump_select,
	output logic pump_code_ok,
	output logic [3:0] prescale_ratio,
	output logic prescale_ok,
	output logic [7:0] m_ratio,
	output logic m_ratio_ok,
	output logic [4:0] n_ratio
);

	ratio_state_t s_r; // Registered state
	ratio_state_t s_nxt; // Next state
	logic [2:0] pre_code; // Prescaler code
	logic [7:0] m_code; // M field

	assign pre_code = ctl[`PRE_HI:`PRE_LO];
	assign m_code = div[`M_HI:`M_LO];

	// Decode the pump, prescaler, M and N fields each cycle
	always_comb begin
		s_nxt = s_r;
		s_nxt.pump = charge_pump_t'(ctl[`CP_HI:`CP_LO]);
		s_nxt.pump_ok = ctl[`CP_HI:`CP_LO] != PUMP_UNUSED;
		// Code 001 has no ratio; report it as invalid
		case (pre_code)
			3'h0: begin
				s_nxt.pre = 4'h8;
				s_nxt.pre_ok = 1'b1;
			end
			3'h1: begin
				s_nxt.pre = 4'h0;
				s_nxt.pre_ok = 1'b0;
			end
			default: begin
				s_nxt.pre = {1'b0, pre_code};
				s_nxt.pre_ok = 1'b1;
			end
		endcase
		// Doubled mode gives only even ratios
		if (m_code[7]) begin
			s_nxt.m = {m_code[6:0], 1'b0};
		end else begin
			s_nxt.m = {1'b0, m_code[6:0]};
		end
		s_nxt.m_ok = m_code[6:0] >= `M_MIN;
		s_nxt.n = {1'b0, div[`N_HI:`N_LO]} + 5'h01;
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign charge_pump_select = s_r.pump;
	assign pump_code_ok = s_r.pump_ok;
	assign prescale_ratio = s_r.pre;
	assign prescale_ok = s_r.pre_ok;
	assign m_ratio = s_r.m;
	assign m_ratio_ok = s_r.m_ok;
	assign n_ratio = s_r.n;

	a_n_ratio: assert property (@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> n_ratio == 5'($past(div[7:4])) + 5'h01)
		else $error("n ratio is not code plus one");

	a_m_ratio: assert property (@(posedge sys_clk) disable iff (!rst_b)
		div[15] |=> m_ratio == {$past(div[14:8]), 1'b0})
		else $error("doubled m ratio wrong");

endmodule
`default_nettype wire
